/* shared/uefr_pkg.sv */
// Constants of the endpoint buffer and target register bank.
// Assumes a 32-bit AHB-Lite slave port, one aligned word per register.
package uefr_pkg;

    // ------------------------------------------------------------
    // register map: byte offsets and indices
    // ------------------------------------------------------------
    localparam int unsigned REG_COUNT = 10;
    localparam logic [3:0] IDX_TX_BUFFER_SIZE       = 4'h0;
    localparam logic [3:0] IDX_RX_BUFFER_SIZE       = 4'h1;
    localparam logic [3:0] IDX_TX_BUFFER_START      = 4'h2;
    localparam logic [3:0] IDX_RX_BUFFER_START      = 4'h3;
    localparam logic [3:0] IDX_TX_TARGET_FUNCTION   = 4'h4;
    localparam logic [3:0] IDX_TX_TARGET_HUB        = 4'h5;
    localparam logic [3:0] IDX_TX_TARGET_HUB_PORT   = 4'h6;
    localparam logic [3:0] IDX_RX_TARGET_FUNCTION   = 4'h7;
    localparam logic [3:0] IDX_RX_TARGET_HUB        = 4'h8;
    localparam logic [3:0] IDX_RX_TARGET_HUB_PORT   = 4'h9;
    localparam logic [31:0] OFS_TX_BUFFER_SIZE      = 32'h0000_0000;
    localparam logic [31:0] OFS_RX_BUFFER_SIZE      = 32'h0000_0004;
    localparam logic [31:0] OFS_TX_BUFFER_START     = 32'h0000_0008;
    localparam logic [31:0] OFS_RX_BUFFER_START     = 32'h0000_000C;
    localparam logic [31:0] OFS_TX_TARGET_FUNCTION  = 32'h0000_0010;
    localparam logic [31:0] OFS_TX_TARGET_HUB       = 32'h0000_0014;
    localparam logic [31:0] OFS_TX_TARGET_HUB_PORT  = 32'h0000_0018;
    localparam logic [31:0] OFS_RX_TARGET_FUNCTION  = 32'h0000_001C;
    localparam logic [31:0] OFS_RX_TARGET_HUB       = 32'h0000_0020;
    localparam logic [31:0] OFS_RX_TARGET_HUB_PORT  = 32'h0000_0024;

    // ------------------------------------------------------------
    // field layout, writable masks, reset value
    // ------------------------------------------------------------
    localparam int unsigned REG_W          = 16;
    localparam logic [15:0] REG_RESET      = 16'h0000;
    localparam int unsigned POS_DOUBLE_BUF = 4;
    localparam int unsigned POS_SIZE_LSB   = 0;
    localparam int unsigned SIZE_W         = 4;
    localparam int unsigned START_W        = 13;
    localparam int unsigned ADDR7_W        = 7;
    localparam int unsigned POS_MULTI_TT   = 7;
    localparam logic [15:0] MASK_SIZE      = 16'h001F;
    localparam logic [15:0] MASK_START     = 16'h1FFF;
    localparam logic [15:0] MASK_ADDR7     = 16'h007F;
    localparam logic [15:0] MASK_HUB       = 16'h00FF;

    // ------------------------------------------------------------
    // buffer arithmetic
    // ------------------------------------------------------------
    localparam logic [4:0] EXP_SINGLE      = 5'h03;
    localparam logic [4:0] EXP_DOUBLE      = 5'h04;
    localparam int unsigned START_UNIT_LOG = 3;
    localparam int unsigned BYTES_W        = 20;
    localparam int unsigned PACKET_W       = 19;
    localparam int unsigned START_BYTE_W   = 16;

    // ------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------
    localparam logic [2:0] HSIZE_WORD      = 3'h2;
    localparam int unsigned MAP_TOP_BIT    = 6;

    // writable bits of each register; everything else reads zero
    function automatic logic [15:0] reg_mask(input logic [3:0] idx);
        logic [15:0] m;
        m = 16'h0000;
        unique case (idx)
            IDX_TX_BUFFER_SIZE, IDX_RX_BUFFER_SIZE:         m = MASK_SIZE;
            IDX_TX_BUFFER_START, IDX_RX_BUFFER_START:       m = MASK_START;
            IDX_TX_TARGET_HUB, IDX_RX_TARGET_HUB:           m = MASK_HUB;
            IDX_TX_TARGET_FUNCTION, IDX_RX_TARGET_FUNCTION,
            IDX_TX_TARGET_HUB_PORT, IDX_RX_TARGET_HUB_PORT: m = MASK_ADDR7;
            default:                                        m = 16'h0000;
        endcase
        return m;
    endfunction

endpackage

/* core/uefr_buf_decode.sv */
// Turns one direction's size code, double-buffer bit and start offset
// into byte quantities for the buffer manager. Outputs lag the fields
// by one clock edge; expects hclk and hresetn of the register bank.
module uefr_buf_decode (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [3:0]  size_code,
    input  wire logic        double_buf,
    input  wire logic [12:0] start_units,
    output logic      [19:0] buffer_bytes_r,
    output logic      [18:0] max_packet_bytes_r,
    output logic      [15:0] start_byte_r
);

    logic [4:0] exp_nxt;
    logic [4:0] pkt_exp_nxt;

    // exponents for buffer and packet size
    assign exp_nxt     = {1'b0, size_code} + (double_buf ? uefr_pkg::EXP_DOUBLE
                                                         : uefr_pkg::EXP_SINGLE); // [R1] [R2]
    assign pkt_exp_nxt = {1'b0, size_code} + uefr_pkg::EXP_SINGLE; // [R3]

    // registered byte figures
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buffer_bytes_r     <= 20'h00000;
            max_packet_bytes_r <= 19'h00000;
            start_byte_r       <= 16'h0000;
        end else begin
            buffer_bytes_r     <= 20'h00001 << exp_nxt;        // [R2]
            max_packet_bytes_r <= 19'h00001 << pkt_exp_nxt;    // [R3]
            start_byte_r       <= {start_units, 3'h0};         // [R4]
        end
    end

endmodule

/* core/uefr_regs.sv */
// Endpoint buffer sizing and host target register bank.
// Assumes a single AHB-Lite master; hreadyout feeds back as hready.
// Consumers are the buffer manager and the host transaction engine.
//
// How it works
// R1 - bit 4 of each size register selects one or two packet buffers
// R2 - buffer bytes are 2**(code+3) single, 2**(code+4) double buffered
// R3 - size code 0..15 sets the largest packet, 2**(code+3) bytes
// R4 - 13-bit start offset counts 8-byte units; byte start is eight times it
// R5 - 7-bit target function address per direction, bit 7 reads zero
// R6 - writable 7-bit hub address plus multi translator flag in bit 7
// R7 - software clears the translator flag for single translator hubs
// R8 - 7-bit hub port per direction, bit 7 reads zero
// R9 - software keeps buffers from overlapping and sets them before use
// R10 - reserved bits ignore writes and read zero; fields reset to zero
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
module uefr_regs (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // transmit buffer
    output logic             tx_double_buffer_enable,
    output logic      [3:0]  tx_packet_size_code,
    output logic      [12:0] tx_buffer_start,
    output logic      [19:0] tx_buffer_bytes,
    output logic      [18:0] tx_max_packet_bytes,
    output logic      [15:0] tx_buffer_start_byte,
    // receive buffer
    output logic             rx_double_buffer_enable,
    output logic      [3:0]  rx_packet_size_code,
    output logic      [12:0] rx_buffer_start,
    output logic      [19:0] rx_buffer_bytes,
    output logic      [18:0] rx_max_packet_bytes,
    output logic      [15:0] rx_buffer_start_byte,
    // transmit target
    output logic      [6:0]  tx_function_number,
    output logic      [6:0]  tx_hub_number,
    output logic             tx_multi_translator_flag,
    output logic      [6:0]  tx_hub_port_number,
    // receive target
    output logic      [6:0]  rx_function_number,
    output logic      [6:0]  rx_hub_number,
    output logic             rx_multi_translator_flag,
    output logic      [6:0]  rx_hub_port_number
);

    // ------------------------------------------------------------
    // storage and bus state
    // ------------------------------------------------------------
    logic [15:0] regs_r [uefr_pkg::REG_COUNT];
    logic        wr_pend_r;
    logic [3:0]  wr_idx_r;
    logic        rd_pend_r;
    logic [3:0]  rd_idx_r;
    logic        rd_hit_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;
    logic        hresp_r;

    logic        accept;
    logic [3:0]  addr_idx;
    logic        addr_hit;
    logic        word_write;

    // ------------------------------------------------------------
    // address phase decode
    // ------------------------------------------------------------

    // nonseq or seq with the bus ready starts a transfer
    assign accept     = hsel && hready && htrans[1];
    assign addr_idx   = haddr[5:2];
    // only aligned words inside the bank are mapped
    assign addr_hit   = (haddr[31:uefr_pkg::MAP_TOP_BIT] == 26'h0000000)
                      && (haddr[1:0] == 2'h0)
                      && (32'(addr_idx) < uefr_pkg::REG_COUNT);
    assign word_write = hwrite && (hsize == uefr_pkg::HSIZE_WORD);

    // capture a pending write for its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 4'h0;
        end else begin
            wr_pend_r <= accept && word_write && addr_hit;
            wr_idx_r  <= addr_idx;
        end
    end

    // capture a pending read; it is served after one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_r <= 1'b0;
            rd_idx_r  <= 4'h0;
            rd_hit_r  <= 1'b0;
        end else begin
            rd_pend_r <= accept && !hwrite;
            rd_idx_r  <= addr_idx;
            rd_hit_r  <= addr_hit;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------

    // data phase write; reserved bits are dropped by the mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < uefr_pkg::REG_COUNT; i++) begin
                regs_r[i] <= uefr_pkg::REG_RESET;                            // [R10]
            end
        end else if (wr_pend_r) begin
            regs_r[wr_idx_r] <= hwdata[15:0] & uefr_pkg::reg_mask(wr_idx_r); // [R10]
        end
    end

    // ------------------------------------------------------------
    // read path and bus answer
    // ------------------------------------------------------------

    // read data loads during the wait state, so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
        end else if (rd_pend_r) begin
            hrdata_r <= rd_hit_r ? {16'h0000, regs_r[rd_idx_r]}
                                 : 32'h00000000; // unmapped reads zero [R10]
        end
    end

    // one wait state for each read, none for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b1;
        end else if (accept && !hwrite) begin
            hreadyout_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
        end
    end

    // the bank never signals an error
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp     = hresp_r;

    // ------------------------------------------------------------
    // buffer sizing fields
    // ------------------------------------------------------------

    // double-buffer bit and size code per direction
    assign tx_double_buffer_enable =
        regs_r[uefr_pkg::IDX_TX_BUFFER_SIZE][uefr_pkg::POS_DOUBLE_BUF];        // [R1]
    assign rx_double_buffer_enable =
        regs_r[uefr_pkg::IDX_RX_BUFFER_SIZE][uefr_pkg::POS_DOUBLE_BUF];        // [R1]
    assign tx_packet_size_code =
        regs_r[uefr_pkg::IDX_TX_BUFFER_SIZE][uefr_pkg::POS_SIZE_LSB +: 4];     // [R3]
    assign rx_packet_size_code =
        regs_r[uefr_pkg::IDX_RX_BUFFER_SIZE][uefr_pkg::POS_SIZE_LSB +: 4];     // [R3]

    // start offsets in 8-byte units
    assign tx_buffer_start = regs_r[uefr_pkg::IDX_TX_BUFFER_START][12:0];      // [R4]
    assign rx_buffer_start = regs_r[uefr_pkg::IDX_RX_BUFFER_START][12:0];      // [R4]

    // transmit byte figures
    uefr_buf_decode u_tx_decode (
        .hclk               (hclk),
        .hresetn            (hresetn),
        .size_code          (tx_packet_size_code),
        .double_buf         (tx_double_buffer_enable),
        .start_units        (tx_buffer_start),
        .buffer_bytes_r     (tx_buffer_bytes),
        .max_packet_bytes_r (tx_max_packet_bytes),
        .start_byte_r       (tx_buffer_start_byte)
    );

    // receive byte figures
    uefr_buf_decode u_rx_decode (
        .hclk               (hclk),
        .hresetn            (hresetn),
        .size_code          (rx_packet_size_code),
        .double_buf         (rx_double_buffer_enable),
        .start_units        (rx_buffer_start),
        .buffer_bytes_r     (rx_buffer_bytes),
        .max_packet_bytes_r (rx_max_packet_bytes),
        .start_byte_r       (rx_buffer_start_byte)
    );

    // ------------------------------------------------------------
    // host target fields
    // ------------------------------------------------------------

    // function addresses
    assign tx_function_number = regs_r[uefr_pkg::IDX_TX_TARGET_FUNCTION][6:0]; // [R5]
    assign rx_function_number = regs_r[uefr_pkg::IDX_RX_TARGET_FUNCTION][6:0]; // [R5]

    // hub addresses and translator flag, set or cleared by software
    assign tx_hub_number = regs_r[uefr_pkg::IDX_TX_TARGET_HUB][6:0];           // [R6]
    assign rx_hub_number = regs_r[uefr_pkg::IDX_RX_TARGET_HUB][6:0];           // [R6]
    assign tx_multi_translator_flag =
        regs_r[uefr_pkg::IDX_TX_TARGET_HUB][uefr_pkg::POS_MULTI_TT];           // [R6] [R7]
    assign rx_multi_translator_flag =
        regs_r[uefr_pkg::IDX_RX_TARGET_HUB][uefr_pkg::POS_MULTI_TT];           // [R6] [R7]

    // hub ports
    assign tx_hub_port_number = regs_r[uefr_pkg::IDX_TX_TARGET_HUB_PORT][6:0]; // [R8]
    assign rx_hub_port_number = regs_r[uefr_pkg::IDX_RX_TARGET_HUB_PORT][6:0]; // [R8]

endmodule

/* verif/uefr_regs_chk.sv */
// Assertion checker for the endpoint buffer and target register bank.
// Bound into uefr_regs; sees only its ports, one clock domain.
module uefr_regs_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        tx_double_buffer_enable,
    input wire logic [3:0]  tx_packet_size_code,
    input wire logic [12:0] tx_buffer_start,
    input wire logic [19:0] tx_buffer_bytes,
    input wire logic [18:0] tx_max_packet_bytes,
    input wire logic [15:0] tx_buffer_start_byte,
    input wire logic        rx_double_buffer_enable,
    input wire logic [3:0]  rx_packet_size_code,
    input wire logic [12:0] rx_buffer_start,
    input wire logic [19:0] rx_buffer_bytes,
    input wire logic [15:0] rx_buffer_start_byte,
    input wire logic [6:0]  tx_function_number,
    input wire logic [6:0]  tx_hub_number,
    input wire logic        tx_multi_translator_flag,
    input wire logic [6:0]  rx_hub_port_number
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // helpers and properties
    // ----------------------------------------
    logic       warm_r; // set at the first edge after release
    logic       live_r; // decoded outputs and past values valid from the second
    wire  [7:0] wd   = hwdata[7:0];
    wire        take = hsel && hready && htrans[1] && hwrite && hsize == 3'h2;

    // two-edge warm-up after every release of reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            warm_r <= 1'b0;
            live_r <= 1'b0;
        end else begin
            warm_r <= 1'b1;
            live_r <= warm_r;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn || !live_r);

    property p_tx_bytes;
        tx_buffer_bytes == (20'h1 << ($past(tx_packet_size_code) + 3 + $past(tx_double_buffer_enable)));
    endproperty
    property p_rx_bytes;
        rx_buffer_bytes == (20'h1 << ($past(rx_packet_size_code) + 3 + $past(rx_double_buffer_enable)));
    endproperty
    property p_tx_max;
        tx_max_packet_bytes == (19'h1 << ($past(tx_packet_size_code) + 3));
    endproperty
    property p_tx_start;
        tx_buffer_start_byte == {$past(tx_buffer_start), 3'h0};
    endproperty
    property p_rx_start;
        rx_buffer_start_byte == {$past(rx_buffer_start), 3'h0};
    endproperty
    property p_tx_func;
        take && haddr == uefr_pkg::OFS_TX_TARGET_FUNCTION |=> ##1
            {1'b0, tx_function_number} == ($past(wd) & 8'h7F);
    endproperty
    property p_tx_hub;
        take && haddr == uefr_pkg::OFS_TX_TARGET_HUB |=> ##1
            {tx_multi_translator_flag, tx_hub_number} == $past(wd);
    endproperty
    property p_rx_port;
        take && haddr == uefr_pkg::OFS_RX_TARGET_HUB_PORT |=> ##1
            {1'b0, rx_hub_port_number} == ($past(wd) & 8'h7F);
    endproperty
    property p_upper_zero;
        hrdata[31:13] == 19'h0;
    endproperty

    a_tx_bytes: assert property (p_tx_bytes) else $error("tx buffer bytes wrong");
    a_rx_bytes: assert property (p_rx_bytes) else $error("rx buffer bytes wrong");
    a_tx_max: assert property (p_tx_max) else $error("tx max packet wrong");
    a_tx_start: assert property (p_tx_start) else $error("tx start byte wrong");
    a_rx_start: assert property (p_rx_start) else $error("rx start byte wrong");
    a_tx_func: assert property (p_tx_func) else $error("tx function not written");
    a_tx_hub: assert property (p_tx_hub) else $error("tx hub not written");
    a_rx_port: assert property (p_rx_port) else $error("rx hub port not written");
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

    c_hub_write: cover property (take && haddr == uefr_pkg::OFS_TX_TARGET_HUB);
    c_big_double: cover property (tx_double_buffer_enable && tx_packet_size_code == 4'hF);
    c_read_wait: cover property (!hreadyout);
endmodule

bind uefr_regs uefr_regs_chk uefr_regs_chk_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .tx_double_buffer_enable, .tx_packet_size_code, .tx_buffer_start,
    .tx_buffer_bytes, .tx_max_packet_bytes, .tx_buffer_start_byte, .rx_double_buffer_enable,
    .rx_packet_size_code, .rx_buffer_start, .rx_buffer_bytes, .rx_buffer_start_byte,
    .tx_function_number, .tx_hub_number, .tx_multi_translator_flag, .rx_hub_port_number
);

/* verif/test_usb_endpoint_fifo_target_regs.sv */
// Self-checking bench for the endpoint buffer and target register bank.
// Assumes uefr_regs alone on the bus, hreadyout fed back as hready.
module test_usb_endpoint_fifo_target_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals, design, bus tasks
    // ----------------------------------------
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hready, hreadyout, hresp, tx_dbl, rx_dbl, tx_mtt, rx_mtt;
    logic [3:0]  tx_code, rx_code;
    logic [12:0] tx_start, rx_start;
    logic [19:0] tx_bytes, rx_bytes;
    logic [18:0] tx_max, rx_max;
    logic [15:0] tx_sbyte, rx_sbyte;
    logic [6:0]  tx_fn, tx_hub, tx_port, rx_fn, rx_hub, rx_port;
    int          err_total = 0, tests_run = 0;
    logic [15:0] msk [10] = '{16'h001F, 16'h001F, 16'h1FFF, 16'h1FFF, 16'h007F,
                              16'h00FF, 16'h007F, 16'h007F, 16'h00FF, 16'h007F};

    assign hready = hreadyout;
    always #5 hclk = ~hclk;

    uefr_regs uefr_regs_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .tx_double_buffer_enable(tx_dbl),
        .tx_packet_size_code(tx_code), .tx_buffer_start(tx_start), .tx_buffer_bytes(tx_bytes),
        .tx_max_packet_bytes(tx_max), .tx_buffer_start_byte(tx_sbyte),
        .rx_double_buffer_enable(rx_dbl), .rx_packet_size_code(rx_code),
        .rx_buffer_start(rx_start), .rx_buffer_bytes(rx_bytes), .rx_max_packet_bytes(rx_max),
        .rx_buffer_start_byte(rx_sbyte), .tx_function_number(tx_fn), .tx_hub_number(tx_hub),
        .tx_multi_translator_flag(tx_mtt), .tx_hub_port_number(tx_port),
        .rx_function_number(rx_fn), .rx_hub_number(rx_hub),
        .rx_multi_translator_flag(rx_mtt), .rx_hub_port_number(rx_port));

    task automatic summarize;
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one single transfer: address phase, then data phase until hready
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do begin @(posedge hclk); end while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge hclk); end while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic chk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        cmp(rd, exp);
    endtask

    task automatic settle;
        repeat (2) @(posedge hclk);
    endtask

    // reset, then every register reads back zero and the tx buffer bytes read 8
    task automatic rst_zero;
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 10; i++) chk(i * 4, 32'h0);
        cmp(tx_bytes, 32'h8);
    endtask

    initial begin
        #100us;
        err_total++;
        summarize();
    end

    initial begin
        rst_zero();
        for (int i = 0; i < 10; i++) begin
            wr(i * 4, 32'hFFFF_FFFF);
            chk(i * 4, {16'h0, msk[i]});
        end
        for (int m = 0; m < 16; m++) begin
            for (int d = 0; d < 2; d++) begin
                wr(uefr_pkg::OFS_TX_BUFFER_SIZE, {27'h0, d[0], m[3:0]});
                wr(uefr_pkg::OFS_RX_BUFFER_SIZE, {27'h0, ~d[0], 4'hF - m[3:0]});
                settle();
                cmp(tx_bytes, 1 << (m + 3 + d));
                cmp(tx_max, 1 << (m + 3));
                cmp(tx_code, m);
                cmp(tx_dbl, d);
                cmp(rx_bytes, 1 << (19 - m - d));
                cmp(rx_max, 1 << (18 - m));
                cmp(rx_dbl, 1 - d);
                cmp(rx_code, 15 - m);
            end
        end
        wr(uefr_pkg::OFS_TX_BUFFER_START, 32'h0000_1FFF);
        wr(uefr_pkg::OFS_RX_BUFFER_START, 32'h0000_E001);
        wr(uefr_pkg::OFS_TX_TARGET_FUNCTION, 32'h0000_05A5);
        wr(uefr_pkg::OFS_TX_TARGET_HUB, 32'h0000_01B3);
        wr(uefr_pkg::OFS_TX_TARGET_HUB_PORT, 32'h0000_0081);
        wr(uefr_pkg::OFS_RX_TARGET_FUNCTION, 32'h0000_0012);
        wr(uefr_pkg::OFS_RX_TARGET_HUB, 32'h0000_007F);
        wr(uefr_pkg::OFS_RX_TARGET_HUB_PORT, 32'h0000_01FF);
        settle();
        cmp({tx_start, tx_sbyte}, {13'h1FFF, 16'hFFF8});
        cmp({rx_start, rx_sbyte}, {13'h1, 16'h8});
        cmp({tx_fn, rx_fn}, {7'h25, 7'h12});
        cmp({tx_mtt, tx_hub, rx_mtt, rx_hub}, 16'hB37F);
        cmp({tx_port, rx_port}, {7'h01, 7'h7F});
        wr(uefr_pkg::OFS_TX_TARGET_HUB, 32'h0000_0033);
        chk(uefr_pkg::OFS_TX_TARGET_HUB, 32'h33);
        // a byte-sized write is dropped entirely
        hsize <= 3'h0;
        wr(uefr_pkg::OFS_TX_TARGET_HUB, 32'h0000_00CC);
        hsize <= 3'h2;
        chk(uefr_pkg::OFS_TX_TARGET_HUB, 32'h33);
        wr(32'h0000_0028, 32'hFFFF_FFFF);
        chk(32'h0000_0028, 32'h0);
        cmp(hresp, 1'b0);
        chk(uefr_pkg::OFS_TX_TARGET_FUNCTION, 32'h25);
        rst_zero();
        summarize();
    end
endmodule
